// ### verilog/ddc_top.sv
// ddc_top: two-stage oscillator downconverter, decimators, spi registers, fifo
`timescale 1ns/10ps
module ddc_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   // depth must be a power of two so pointers wrap by themselves
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [0:D-1];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready_out = cnt_r != (AW+1)'(D);
   assign out_valid_out = cnt_r != '0;
   assign out_data_out = mem[rp_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wp_r] <= in_data_in;
      end
   end
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      end
   end
endmodule : ddc_fifo

module ddc_top
   import ddc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // converter stream and back-pressure
   input wire logic [4:0] adc_sample_in,
   output logic sample_ready_out,
   // synchronisation pin
   input wire logic sysref_in,
   // spi port
   input wire logic spi_clk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_mosi_in,
   output logic spi_miso_out,
   output logic spi_miso_oe_n_out,
   // complex output
   output logic iq_valid_out,
   output logic [IQ_W-1:0] iq_i_out,
   output logic [IQ_W-1:0] iq_q_out,
   input wire logic iq_ready_in
);
   logic [3:0] pin_raw;
   logic [2:0] pin_sy_r [0:3];
   logic pin_st_r [0:3];
   logic pin_rise_r [0:3];
   logic pin_fall_r [0:3];
   assign pin_raw = {sysref_in, spi_mosi_in, spi_cs_n_in, spi_clk_in};
   // three flops; a change counts once the last two agree
   for (genvar p = 0; p < 4; p++) begin : g_pin
      always_ff @(posedge clk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            pin_sy_r[p] <= {3{PIN_RST[p]}};
            pin_st_r[p] <= PIN_RST[p];
            pin_rise_r[p] <= 1'b0;
            pin_fall_r[p] <= 1'b0;
         end else begin
            pin_sy_r[p] <= {pin_sy_r[p][1:0], pin_raw[p]};
            pin_rise_r[p] <= pin_sy_r[p][1] && pin_sy_r[p][2] && !pin_st_r[p];
            pin_fall_r[p] <= !pin_sy_r[p][1] && !pin_sy_r[p][2] && pin_st_r[p];
            if (pin_sy_r[p][1] == pin_sy_r[p][2]) pin_st_r[p] <= pin_sy_r[p][2];
         end
      end
   end

   // spi: 24-bit frames, rw bit, 15-bit address, 8-bit data, msb first
   logic [22:0] sh_r;
   logic [4:0] bit_r;
   logic [7:0] rd_sh_r;
   logic miso_r;
   logic oe_n_r;
   logic wr_r;
   logic [14:0] wr_adr_r;
   logic [7:0] wr_dat_r;
   logic [14:0] rd_adr;
   logic [7:0] rd_val;
   assign rd_adr = {sh_r[13:0], pin_st_r[PIN_MOSI]};
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sh_r <= '0;
         bit_r <= '0;
         rd_sh_r <= '0;
         miso_r <= 1'b0;
         oe_n_r <= 1'b1;
         wr_r <= 1'b0;
         wr_adr_r <= '0;
         wr_dat_r <= '0;
      end else begin
         wr_r <= 1'b0;
         if (pin_st_r[PIN_CS]) begin
            bit_r <= '0;
            oe_n_r <= 1'b1;
         end else begin
            if (pin_rise_r[PIN_SCLK]) begin
               sh_r <= {sh_r[21:0], pin_st_r[PIN_MOSI]};
               bit_r <= bit_r + 1'b1;
               if (bit_r == SPI_ADDR_LAST && sh_r[14]) begin
                  rd_sh_r <= rd_val;
                  oe_n_r <= 1'b0;
               end
               if (bit_r == SPI_LAST && !sh_r[22]) begin
                  wr_r <= 1'b1;
                  wr_adr_r <= sh_r[21:7];
                  wr_dat_r <= {sh_r[6:0], pin_st_r[PIN_MOSI]};
               end
            end
            if (pin_fall_r[PIN_SCLK] && !oe_n_r) begin
               miso_r <= rd_sh_r[7];
               rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
         end
      end
   end
   assign spi_miso_out = miso_r;
   assign spi_miso_oe_n_out = oe_n_r;

   logic [2:0] dec_r;
   logic [5:0] coarse_r;
   logic [7:0] fine_r;
   logic [5:0] cinit_r;
   logic [9:0] finit_r;
   logic [15:0] fadc_r;
   logic [15:0] fif_r;
   logic ovf_r;
   logic drop;
   ddc_calc_t calc_r;
   logic [12:0] q_r;
   logic [16:0] rem_r;
   logic [3:0] step_r;
   logic [5:0] crs_w;
   logic [7:0] fin_w;
   logic busy;
   logic dec_wr;
   logic calc_go;
   logic sync_ev;
   logic restart;
   assign busy = calc_r != CALC_IDLE;
   assign dec_wr = wr_r && wr_adr_r == ADR_DEC;
   assign calc_go = dec_wr || (wr_r && wr_adr_r >= ADR_FADC_LO && wr_adr_r <= ADR_FIF_HI);
   assign sync_ev = pin_rise_r[PIN_SYSREF];
   // counters restart on sysref and on a new factor so the delay stays fixed
   assign restart = sync_ev || dec_wr;

   always_comb begin
      case (rd_adr)
         ADR_FADC_LO: rd_val = fadc_r[7:0];
         ADR_FADC_HI: rd_val = fadc_r[15:8];
         ADR_FIF_LO: rd_val = fif_r[7:0];
         ADR_FIF_HI: rd_val = fif_r[15:8];
         ADR_DEC: rd_val = {5'h00, dec_r};
         ADR_COARSE: rd_val = {2'h0, coarse_r};
         ADR_FINE: rd_val = fine_r;
         ADR_CINIT: rd_val = {2'h0, cinit_r};
         ADR_FINIT_LO: rd_val = finit_r[7:0];
         ADR_FINIT_HI: rd_val = {6'h00, finit_r[9:8]};
         ADR_STATUS: rd_val = {6'h00, ovf_r, busy};
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dec_r <= DEC_32;
         cinit_r <= '0;
         finit_r <= '0;
         fadc_r <= '0;
         fif_r <= '0;
      end else if (wr_r) begin
         case (wr_adr_r)
            ADR_FADC_LO: fadc_r[7:0] <= wr_dat_r;
            ADR_FADC_HI: fadc_r[15:8] <= wr_dat_r;
            ADR_FIF_LO: fif_r[7:0] <= wr_dat_r;
            ADR_FIF_HI: fif_r[15:8] <= wr_dat_r;
            ADR_CINIT: cinit_r <= wr_dat_r[5:0];
            ADR_FINIT_LO: finit_r[7:0] <= wr_dat_r;
            ADR_FINIT_HI: finit_r[9:8] <= wr_dat_r[1:0];
            // an unlisted factor is ignored, the old one stays
            ADR_DEC: if (wr_dat_r[2:0] >= DEC_32 && wr_dat_r[2:0] <= DEC_12) dec_r <= wr_dat_r[2:0];
            default: ;
         endcase
      end
   end

   // overflow: a drop in the clearing cycle still sets the flag
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) ovf_r <= 1'b0;
      else if (drop) ovf_r <= 1'b1;
      else if (wr_r && wr_adr_r == ADR_STATUS && wr_dat_r[STAT_OVF]) ovf_r <= 1'b0;
   end

   // tuning word calculation: ratio IF/converter rate with 13 fraction bits
   logic [16:0] rem_sh;
   logic [13:0] crs_sum;
   logic signed [15:0] res_w;
   logic signed [15:0] f4096;
   logic signed [15:0] f3072;
   assign rem_sh = {rem_r[15:0], 1'b0};
   always_comb begin
      crs_sum = {1'b0, q_r} + CRS_ROUND;
      crs_w = crs_sum[12:7];
      res_w = $signed({3'h0, q_r}) - $signed({2'h0, crs_sum[13:7], 7'h00});
      f4096 = (res_w + 16'sh0001) >>> 1;
      f3072 = (res_w * 16'sh0003 + 16'sh0004) >>> 3;
      fin_w = (dec_r == DEC_24 || dec_r == DEC_12) ? f3072[7:0] : f4096[7:0];
   end
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         calc_r <= CALC_IDLE;
         q_r <= '0;
         rem_r <= '0;
         step_r <= '0;
      end else begin
         case (calc_r)
            CALC_IDLE: if (calc_go) begin
               rem_r <= {1'b0, fif_r};
               step_r <= '0;
               calc_r <= CALC_DIV;
            end
            CALC_DIV: begin
               if (rem_sh >= {1'b0, fadc_r}) begin
                  rem_r <= rem_sh - {1'b0, fadc_r};
                  q_r <= {q_r[11:0], 1'b1};
               end else begin
                  rem_r <= rem_sh;
                  q_r <= {q_r[11:0], 1'b0};
               end
               step_r <= step_r + 1'b1;
               if (step_r == DIV_LAST) calc_r <= CALC_DONE;
            end
            CALC_DONE: calc_r <= CALC_IDLE;
            default: calc_r <= CALC_IDLE;
         endcase
      end
   end
   // the calculated words win over a spi write in the same cycle
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         coarse_r <= '0;
         fine_r <= '0;
      end else if (calc_r == CALC_DONE) begin
         coarse_r <= crs_w;
         fine_r <= fin_w;
      end else if (wr_r && wr_adr_r == ADR_COARSE) begin
         coarse_r <= wr_dat_r[5:0];
      end else if (wr_r && wr_adr_r == ADR_FINE) begin
         fine_r <= wr_dat_r;
      end
   end

   // factor decode
   logic d1_three;
   logic four_on;
   logic [1:0] d1_m1;
   logic [5:0] tot_m1;
   assign d1_three = dec_r == DEC_24 || dec_r == DEC_12;
   assign d1_m1 = d1_three ? D1_THREE_M1 : D1_FOUR_M1;
   assign four_on = dec_r == DEC_32 || dec_r == DEC_24;
   always_comb begin
      case (dec_r)
         DEC_32: tot_m1 = TOT_32_M1;
         DEC_24: tot_m1 = TOT_24_M1;
         DEC_16: tot_m1 = TOT_16_M1;
         default: tot_m1 = TOT_12_M1;
      endcase
   end

   // coarse oscillator and mixer at the converter rate
   logic [5:0] cph_r;
   logic signed [13:0] cm_r [0:1];
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cph_r <= '0;
         cm_r[0] <= '0;
         cm_r[1] <= '0;
      end else begin
         cph_r <= sync_ev ? cinit_r : cph_r + coarse_r;
         cm_r[0] <= $signed(adc_sample_in) * ddc_sin(cph_r + QUARTER);
         cm_r[1] <= -($signed(adc_sample_in) * ddc_sin(cph_r));
      end
   end

   // first stage: symmetric boxcar over three or four samples
   logic [1:0] cnt1_r;
   logic s1_v_r;
   logic signed [15:0] s1_r [0:1];
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt1_r <= '0;
         s1_v_r <= 1'b0;
      end else if (restart) begin
         cnt1_r <= '0;
         s1_v_r <= 1'b0;
      end else begin
         s1_v_r <= cnt1_r == d1_m1;
         cnt1_r <= (cnt1_r == d1_m1) ? 2'h0 : cnt1_r + 1'b1;
      end
   end
   for (genvar c = 0; c < 2; c++) begin : g_s1
      logic signed [15:0] acc_r;
      always_ff @(posedge clk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            acc_r <= '0;
            s1_r[c] <= '0;
         end else if (restart) begin
            acc_r <= '0;
         end else if (cnt1_r == d1_m1) begin
            s1_r[c] <= acc_r + cm_r[c];
            acc_r <= '0;
         end else begin
            acc_r <= acc_r + cm_r[c];
         end
      end
   end

   // fine oscillator runs at the first-stage output rate
   logic [9:0] fph_r;
   logic signed [8:0] fc;
   logic signed [8:0] fs;
   logic signed [25:0] fm_i;
   logic signed [25:0] fm_q;
   logic signed [15:0] hb_x [0:3][0:1];
   logic hb_v [0:3];
   logic hb_ph_r [0:2];
   // lookup uses the top six phase bits: finer words still steer, spurs rise
   assign fc = ddc_sin(fph_r[9:4] + QUARTER);
   assign fs = ddc_sin(fph_r[9:4]);
   assign fm_i = s1_r[0] * fc + s1_r[1] * fs;
   assign fm_q = s1_r[1] * fc - s1_r[0] * fs;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fph_r <= '0;
         hb_v[0] <= 1'b0;
         hb_x[0][0] <= '0;
         hb_x[0][1] <= '0;
      end else begin
         if (sync_ev) fph_r <= finit_r;
         else if (s1_v_r) fph_r <= fph_r + {{2{fine_r[7]}}, fine_r};
         hb_v[0] <= s1_v_r && !restart;
         if (s1_v_r) begin
            hb_x[0][0] <= fm_i[MIX_SHIFT+15:MIX_SHIFT];
            hb_x[0][1] <= fm_q[MIX_SHIFT+15:MIX_SHIFT];
         end
      end
   end

   // halving stages 2, 3 and 4 with taps 1 2 1
   for (genvar k = 0; k < 3; k++) begin : g_hb
      always_ff @(posedge clk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            hb_ph_r[k] <= 1'b0;
            hb_v[k+1] <= 1'b0;
         end else if (restart) begin
            hb_ph_r[k] <= 1'b0;
            hb_v[k+1] <= 1'b0;
         end else begin
            hb_v[k+1] <= hb_v[k] && hb_ph_r[k];
            if (hb_v[k]) hb_ph_r[k] <= !hb_ph_r[k];
         end
      end
      for (genvar c = 0; c < 2; c++) begin : g_ch
         logic signed [15:0] z1_r;
         logic signed [15:0] z2_r;
         logic signed [17:0] sum;
         assign sum = hb_x[k][c] + (z1_r <<< 1) + z2_r;
         always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               z1_r <= '0;
               z2_r <= '0;
               hb_x[k+1][c] <= '0;
            end else if (hb_v[k]) begin
               z1_r <= hb_x[k][c];
               z2_r <= z1_r;
               if (hb_ph_r[k]) hb_x[k+1][c] <= sum[17:2];
            end
         end
      end
   end

   // final stage select, then a fixed pad of whole output samples
   logic fin_v;
   logic [31:0] fin_d;
   logic [31:0] dl_mem [0:DL_DEPTH-1];
   logic [5:0] wp_r;
   logic [5:0] fill_r;
   logic [5:0] pad;
   logic push_v_r;
   logic [31:0] push_d_r;
   logic fifo_rdy;
   logic fo_v;
   logic fo_rdy;
   logic [31:0] fo_d;
   logic rdy_r;
   logic iq_v_r;
   logic [31:0] iq_r;
   assign fin_v = four_on ? hb_v[3] : hb_v[2];
   assign fin_d = four_on ? {hb_x[3][0], hb_x[3][1]} : {hb_x[2][0], hb_x[2][1]};
   assign pad = four_on ? PAD_ONE : PAD_TWO;
   assign drop = push_v_r && !fifo_rdy;
   always_ff @(posedge clk_in) begin
      if (fin_v) dl_mem[wp_r] <= fin_d;
   end
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wp_r <= '0;
         fill_r <= '0;
         push_v_r <= 1'b0;
         push_d_r <= '0;
      end else begin
         push_v_r <= fin_v && fill_r == pad;
         push_d_r <= dl_mem[6'(wp_r - pad)];
         if (restart) fill_r <= '0;
         else if (fin_v && fill_r != pad) fill_r <= fill_r + 1'b1;
         if (fin_v) wp_r <= wp_r + 1'b1;
      end
   end

   ddc_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .in_valid_in(push_v_r),
      .in_ready_out(fifo_rdy),
      .in_data_in(push_d_r),
      .out_valid_out(fo_v),
      .out_ready_in(fo_rdy),
      .out_data_out(fo_d)
   );
   assign fo_rdy = !iq_v_r || iq_ready_in;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         iq_v_r <= 1'b0;
         iq_r <= '0;
         rdy_r <= 1'b0;
      end else begin
         rdy_r <= fifo_rdy;
         if (fo_rdy) begin
            iq_v_r <= fo_v;
            iq_r <= fo_d;
         end
      end
   end
   assign sample_ready_out = rdy_r;
   assign iq_valid_out = iq_v_r;
   assign iq_i_out = iq_r[31:16];
   assign iq_q_out = iq_r[15:0];

   // cycles between final outputs, for the checks below
   logic [5:0] gap_r;
   logic seen_r;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap_r <= '0;
         seen_r <= 1'b0;
      end else if (restart) begin
         gap_r <= '0;
         seen_r <= 1'b0;
      end else if (fin_v) begin
         gap_r <= '0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 1'b1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   dec_legal_a: assert property (dec_r >= DEC_32 && dec_r <= DEC_12)
      else $error("factor selector out of range");
   out_spacing_a: assert property (fin_v && seen_r |-> gap_r == tot_m1)
      else $error("output spacing differs from total factor");
   st1_three_a: assert property (disable iff (!reset_n_in || restart)
      s1_v_r && d1_three |=> !s1_v_r [*2] ##1 s1_v_r)
      else $error("first stage not dividing by three");
   st1_four_a: assert property (disable iff (!reset_n_in || restart)
      s1_v_r && !d1_three |=> !s1_v_r [*3] ##1 s1_v_r)
      else $error("first stage not dividing by four");
   coarse_sync_a: assert property (sync_ev ##1 !sync_ev |-> cph_r == $past(cinit_r)
      ##1 cph_r == 6'($past(cinit_r, 2) + $past(coarse_r)))
      else $error("coarse phase not loaded and advanced");
   fine_sync_a: assert property (sync_ev |=> fph_r == $past(finit_r))
      else $error("fine phase not loaded on sysref");
   calc_time_a: assert property ($rose(busy) |-> busy [*8] ##1 busy [*6] ##1 !busy)
      else $error("tuning calculation length wrong");
   fine_range_a: assert property (calc_r == CALC_DONE |=> $signed(fine_r) >= -8'sd32
      && $signed(fine_r) <= 8'sd32)
      else $error("fine word beyond residual range");
   out_hold_a: assert property (iq_v_r && !iq_ready_in |=> iq_v_r && $stable(iq_r))
      else $error("output dropped while stalled");
   pad_full_a: assert property (push_v_r |-> $past(fill_r) == $past(pad))
      else $error("sample pushed before pad filled");
   out12_c: cover property (fin_v && seen_r && dec_r == DEC_12);
   out32_c: cover property (fin_v && seen_r && dec_r == DEC_32);
   sync_c: cover property (sync_ev ##[1:40] s1_v_r);
   calc_c: cover property (calc_r == CALC_DONE);
endmodule : ddc_top

// ### verilog/ddc_pkg.sv
// ddc_pkg: constants, register map and oscillator lookup for the downconverter
// Operation
// - mix coarsely on converter samples, finely after the first decimator
// - coarse oscillator has a 6-bit word, fine one 10-bit phase resolution
// - combined step is converter rate over 3072 or 4096 per first factor
// - selector bits 2:0: 1=32, 2=24, 3=16, 4=12 total decimation
// - tuning words are computed from converter rate and IF after set-up
// - coarse word is round(64 * IF / converter rate), unsigned 6 bits
// - fine word is round(M * residual ratio), 8-bit two's complement
// - M is 3072 for selector 2 and 4, 4096 for 1 and 3
// - on SYSREF the coarse phase loads its initial value, lsb 1/64 cycle
// - on SYSREF the fine phase loads its initial value, lsb 1/1024 cycle
// - only factors 12, 16, 24 and 32 are accepted
// - matched I and Q symmetric FIR decimators in four stages
// - first stage divides by three when factor divisible by three, else four
// - second and third stages halve; third stage output ends 12 and 16
// - fourth halving stage used for 24 and 32, bypassed for 12 and 16
// - all stages use symmetric coefficients for linear phase
// - converter to filter output delay is fixed and deterministic
// - latency 34.2 output samples one lane, 32.3 for two lanes
// - input is a real 5-bit sample every converter clock
package ddc_pkg;
   localparam logic [14:0] ADR_FADC_LO = 15'h100;
   localparam logic [14:0] ADR_FADC_HI = 15'h101;
   localparam logic [14:0] ADR_FIF_LO = 15'h102;
   localparam logic [14:0] ADR_FIF_HI = 15'h103;
   localparam logic [14:0] ADR_DEC = 15'h140;
   localparam logic [14:0] ADR_COARSE = 15'h141;
   localparam logic [14:0] ADR_FINE = 15'h142;
   localparam logic [14:0] ADR_CINIT = 15'h143;
   localparam logic [14:0] ADR_FINIT_LO = 15'h144;
   localparam logic [14:0] ADR_FINIT_HI = 15'h145;
   localparam logic [14:0] ADR_STATUS = 15'h146;
   localparam int STAT_BUSY = 0;
   localparam int STAT_OVF = 1;
   localparam logic [2:0] DEC_32 = 3'h1;
   localparam logic [2:0] DEC_24 = 3'h2;
   localparam logic [2:0] DEC_16 = 3'h3;
   localparam logic [2:0] DEC_12 = 3'h4;
   localparam logic [5:0] TOT_32_M1 = 6'h1f;
   localparam logic [5:0] TOT_24_M1 = 6'h17;
   localparam logic [5:0] TOT_16_M1 = 6'h0f;
   localparam logic [5:0] TOT_12_M1 = 6'h0b;
   localparam logic [1:0] D1_THREE_M1 = 2'h2;
   localparam logic [1:0] D1_FOUR_M1 = 2'h3;
   localparam logic [4:0] SPI_ADDR_LAST = 5'h0f;
   localparam logic [4:0] SPI_LAST = 5'h17;
   localparam int PIN_SCLK = 0;
   localparam int PIN_CS = 1;
   localparam int PIN_MOSI = 2;
   localparam int PIN_SYSREF = 3;
   localparam logic [3:0] PIN_RST = 4'h2;
   localparam logic [3:0] DIV_LAST = 4'hc;
   localparam logic [13:0] CRS_ROUND = 14'h0040;
   localparam int MIX_SHIFT = 7;
   localparam logic [5:0] QUARTER = 6'h10;
   localparam int LAT_ONE_X10 = 342;
   localparam int LAT_TWO_X10 = 323;
   localparam logic [5:0] PAD_ONE = 6'(LAT_ONE_X10 / 10);
   localparam logic [5:0] PAD_TWO = 6'(LAT_TWO_X10 / 10);
   localparam int DL_DEPTH = 64;
   localparam int FIFO_DEPTH = 16;
   localparam int IQ_W = 16;
   typedef enum logic [1:0] {CALC_IDLE, CALC_DIV, CALC_DONE} ddc_calc_t;
   localparam logic [7:0] SIN_Q [0:16] = '{8'h00, 8'h0c, 8'h19, 8'h25, 8'h31, 8'h3c, 8'h47, 8'h51,
      8'h5a, 8'h62, 8'h6a, 8'h70, 8'h75, 8'h7a, 8'h7d, 8'h7e, 8'h7f};

   // 64-point sine from a quarter table, amplitude 127
   function automatic logic signed [8:0] ddc_sin(input logic [5:0] ph);
      logic [4:0] idx;
      logic signed [8:0] mag;
      idx = ph[4] ? 5'(5'h10 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
      mag = $signed({1'b0, SIN_Q[idx]});
      return ph[5] ? -mag : mag;
   endfunction : ddc_sin
endpackage : ddc_pkg

// ### test/ddc_host_sink.sv
// ddc_host_sink: host-side sink for complex words, stalls on command
`timescale 1ns/10ps
module ddc_host_sink (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // stream from the block
   input wire logic iq_valid_in,
   input wire logic stall_in,
   output logic iq_ready_out,
   output logic [15:0] words_out
);
   // the host's own residual offset mixer is not modelled, only acceptance
   assign iq_ready_out = !stall_in;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) words_out <= 16'h0000;
      else if (iq_valid_in && iq_ready_out) words_out <= words_out + 16'h0001;
   end
endmodule : ddc_host_sink

// ### test/tb.sv
// tb: self-checking bench for the downconverter over its spi port and stream
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
   import ddc_pkg::*;
   logic clk_in = 1'b0, reset_n_in = 1'b0, sysref = 1'b0, sck = 1'b0, cs_n = 1'b1, mosi = 1'b0, stall = 1'b0;
   logic [4:0] adc = 5'h0f;
   logic miso, valid, ready, oe_n, oe_rd, srdy;
   logic [15:0] words, iq_i, iq_q;
   logic [7:0] rd;
   logic [7:0] fine_exp [1:4] = '{8'hf3, 8'hf6, 8'hf3, 8'hf6};
   int tot [1:4] = '{32, 24, 16, 12};
   int mismatches = 0, checked = 0, cycles = 0;
   always #2 clk_in = ~clk_in;
   ddc_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .adc_sample_in(adc), .sample_ready_out(srdy),
      .sysref_in(sysref), .spi_clk_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
      .spi_miso_oe_n_out(oe_n), .iq_valid_out(valid), .iq_i_out(iq_i), .iq_q_out(iq_q), .iq_ready_in(ready));
   ddc_host_sink host (.clk_in(clk_in), .reset_n_in(reset_n_in), .iq_valid_in(valid), .stall_in(stall),
      .iq_ready_out(ready), .words_out(words));
   // ceiling well above the roughly 16k cycles the tests need
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic cw(int n);
      repeat (n) @(negedge clk_in);
   endtask : cw
   // spi half period of 10 clocks keeps clear of the 3-flop synchronisers
   task automatic spi(input logic [23:0] f);
      cs_n = 1'b0;
      for (int b = 23; b >= 0; b--) begin
         mosi = f[b];
         cw(10);
         if (b < 8) begin
            rd[b] = miso;
            oe_rd = oe_n;
         end
         sck = 1'b1;
         cw(10);
         sck = 1'b0;
      end
      cw(10);
      cs_n = 1'b1;
      cw(40);
   endtask : spi
   task automatic wr(logic [14:0] a, logic [7:0] d);
      spi({1'b0, a, d});
   endtask : wr
   task automatic rdreg(logic [14:0] a);
      spi({1'b1, a, 8'h00});
   endtask : rdreg
   // cycles between the third and fourth accepted words
   task automatic gap(output int g);
      for (int k = 0; k < 4; k++) begin
         g = 0;
         do begin @(negedge clk_in); g++; end while (!(valid && ready) && g < 4000);
      end
   endtask : gap
   task automatic t_reset();
      rdreg(ADR_DEC);
      `CHK(rd, 8'h01)
      `CHK(oe_rd, 1'b0)
      rdreg(15'h7ff0);
      `CHK(rd, 8'h00)
      `CHK(oe_n, 1'b1)
      `CHK(srdy, 1'b1)
      $display("test reset done");
   endtask : t_reset
   // rate 3200, if 140: coarse round(2.8)=3, fine round(-0.003125*M), M 4096 or 3072
   task automatic t_modes();
      int g;
      wr(ADR_FADC_LO, 8'h80);
      wr(ADR_FADC_HI, 8'h0c);
      wr(ADR_FIF_LO, 8'h8c);
      wr(ADR_FIF_HI, 8'h00);
      for (int s = 1; s <= 4; s++) begin
         wr(ADR_DEC, 8'(s));
         rdreg(ADR_COARSE);
         `CHK(rd, 8'h03)
         rdreg(ADR_FINE);
         `CHK(rd, fine_exp[s])
         gap(g);
         `CHK(g, tot[s])
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_refuse();
      wr(ADR_DEC, 8'h00);
      wr(ADR_DEC, 8'h05);
      rdreg(ADR_DEC);
      `CHK(rd, 8'h04)
      wr(ADR_CINIT, 8'hea);
      wr(ADR_FINIT_HI, 8'hff);
      rdreg(ADR_CINIT);
      `CHK(rd, 8'h2a)
      rdreg(ADR_FINIT_HI);
      `CHK(rd, 8'h03)
      $display("test refuse done");
   endtask : t_refuse
   // a stalled host must overflow the 16-word buffer and raise the drop flag
   task automatic t_stall();
      logic [15:0] w0;
      logic [31:0] iq0;
      stall = 1'b1;
      sysref = 1'b1;
      cw(8);
      sysref = 1'b0;
      // pad refill plus sixteen buffered words must pass before the first drop
      cw(700);
      w0 = words;
      iq0 = {iq_i, iq_q};
      `CHK(valid, 1'b1)
      rdreg(ADR_STATUS);
      `CHK(words, w0)
      `CHK(iq_i, iq0[31:16])
      `CHK(iq_q, iq0[15:0])
      `CHK(rd[1], 1'b1)
      `CHK(srdy, 1'b0)
      stall = 1'b0;
      cw(400);
      wr(ADR_STATUS, 8'h02);
      rdreg(ADR_STATUS);
      `CHK(rd[1], 1'b0)
      $display("test stall done");
   endtask : t_stall
   initial begin
      cw(10);
      reset_n_in = 1'b1;
      cw(10);
      t_reset();
      t_modes();
      t_refuse();
      t_stall();
      tally_and_finish();
   end
endmodule : tb
